// ### bench/counter_slave_chk.sv
// Purpose: Port assertions of the counter slave
// Assumes: One clock domain
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module counter_slave_chk
   import modbus_counter_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Watched ports
   input wire logic rxValid,
   input wire logic rxFrameEnd,
   input wire modbus_counter_pkg::byte_t txData,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic clearEncoder,
   input wire logic restart,
   input wire logic moduleRestart,
   input wire modbus_counter_pkg::byte_t stationAddr,
   input wire modbus_counter_pkg::baud_t baudCode,
   input wire modbus_counter_pkg::parity_t parityCode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Gap cycle inside a read reply is not idle
   sequence s_quiet;
      !txValid && !$past(txValid) && !rxValid && !rxFrameEnd;
   endsequence
   sequence s_opened;
      rxFrameEnd ##1 txValid;
   endsequence
   property p_baud; baudCode >= 4'h4 && baudCode <= 4'hA; endproperty
   property p_par; parityCode != 2'h3; endproperty
   property p_active; $changed({stationAddr, baudCode, parityCode}) |-> ##[0:1] moduleRestart;
   endproperty
   property p_restart; s_quiet ##0 restart |-> ##[1:2] moduleRestart; endproperty
   property p_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
   property p_opened; s_opened |-> txData == stationAddr; endproperty
   property p_rise; $rose(txValid) |-> $past(rxFrameEnd) || $past(txValid, 2); endproperty
   property p_clear; clearEncoder |-> $past(rxFrameEnd) ##1 !clearEncoder; endproperty
   a_baud: assert property (p_baud) else $error("baud code out of range");
   a_par: assert property (p_par) else $error("parity code out of range");
   a_active: assert property (p_active) else $error("settings moved without restart");
   a_restart: assert property (p_restart) else $error("restart not applied");
   a_hold: assert property (p_hold) else $error("reply byte dropped");
   a_opened: assert property (p_opened) else $error("reply not led by address");
   a_rise: assert property (p_rise) else $error("reply without frame");
   a_clear: assert property (p_clear) else $error("clear pulse wrong");
endmodule
bind modbus_rtu_counter_slave counter_slave_chk u_chk (
   .clk(clk), .rstn(rstn), .rxValid(rxValid), .rxFrameEnd(rxFrameEnd), .txData(txData),
   .txValid(txValid), .txReady(txReady), .clearEncoder(clearEncoder), .restart(restart),
   .moduleRestart(moduleRestart), .stationAddr(stationAddr), .baudCode(baudCode),
   .parityCode(parityCode)
);
`default_nettype wire

// ### bench/rtu_master_model.sv
// Purpose: Modbus RTU master on the slave byte stream
// Assumes: One byte a cycle, frame gap as a pulse
// Notes: Optional stall pattern on txReady
`timescale 1ns/1ps
`include "modbus_counter_regs.svh"
`default_nettype none
module rtu_master_model
   import modbus_counter_pkg::*;
(
   // Clock
   input wire logic clk,
   // Request side
   output var modbus_counter_pkg::byte_t rxData,
   output var logic rxValid,
   output var logic rxFrameEnd,
   // Reply side
   input wire modbus_counter_pkg::byte_t txData,
   input wire logic txValid,
   output var logic txReady,
   input wire logic slow
);
   byte_t reply[$];
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      rxFrameEnd = 1'b0;
      txReady = 1'b0;
   end
   function automatic word_t crc_step(input word_t c, input byte_t b);
      word_t r;
      r = c ^ {8'h00, b};
      for (int j = 0; j < 8; j++) begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
   always @(posedge clk) begin
      txReady <= slow ? ~txReady : 1'b1;
   end
   // Sampled mid-cycle, away from the design's edge
   always @(negedge clk) begin
      if (txValid && txReady) begin
         reply.push_back(txData);
      end
   end
   task automatic send(input byte_t m[6], input logic bad);
      word_t c;
      c = `CRC_INIT;
      reply.delete();
      for (int i = 0; i < 6; i++) begin
         c = crc_step(c, m[i]);
      end
      c = c ^ {15'h0, bad};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rxValid <= 1'b1;
         rxData <= (i < 6) ? m[i] : ((i == 6) ? c[7:0] : c[15:8]);
      end
      @(posedge clk);
      rxValid <= 1'b0;
      // Idle line must not repeat the last byte
      rxData <= ~rxData;
      rxFrameEnd <= 1'b1;
      @(posedge clk);
      rxFrameEnd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### bench/tb_modbus_rtu_counter_slave.sv
// Purpose: Self-checking bench of the counter slave
// Assumes: Default station address 0x02
// Notes: Replies checked byte by byte, CRC included
`timescale 1ns/1ps
`include "modbus_counter_regs.svh"
`default_nettype none
module tb_modbus_rtu_counter_slave;
   import modbus_counter_pkg::*;
   logic clk = 1'b0;
   // Driven in the initial block so the falling edge reaches the async reset
   logic rstn;
   logic restart = 1'b0;
   logic slow = 1'b0;
   logic txReady, txValid, rxValid, rxFrameEnd, clearEncoder, moduleRestart;
   byte_t rxData, txData, stationAddr;
   baud_t baudCode;
   parity_t parityCode;
   logic [31:0] encoderCount = 32'hFFFFCA90;
   logic [31:0] channelCount = 32'h1234ABCD;
   int failures = 0;
   int checkCount = 0;
   int cycles = 0;
   int clears = 0;
   int restarts = 0;
   byte_t badFrames[8][6] = '{'{8'h03, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02},
      '{8'h02, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00}, '{8'h02, 8'h03, 8'h00, 8'h10, 8'h00, 8'h11},
      '{8'h02, 8'h06, 8'h00, 8'hC9, 8'h00, 8'h0B}, '{8'h02, 8'h06, 8'h00, 8'hC9, 8'h00, 8'h03},
      '{8'h02, 8'h06, 8'h00, 8'hCA, 8'h00, 8'h03}, '{8'h02, 8'h06, 8'h00, 8'h43, 8'h00, 8'h0B},
      '{8'h02, 8'h06, 8'h00, 8'hC8, 8'h01, 8'h00}};
   always #5 clk = ~clk;
   modbus_rtu_counter_slave u_dut (.clk(clk), .rstn(rstn), .rxData(rxData), .rxValid(rxValid),
      .rxFrameEnd(rxFrameEnd), .txData(txData), .txValid(txValid), .txReady(txReady),
      .encoderCount(encoderCount), .channelCount(channelCount), .clearEncoder(clearEncoder),
      .restart(restart), .moduleRestart(moduleRestart), .stationAddr(stationAddr),
      .baudCode(baudCode), .parityCode(parityCode));
   rtu_master_model u_master (.clk(clk), .rxData(rxData), .rxValid(rxValid),
      .rxFrameEnd(rxFrameEnd), .txData(txData), .txValid(txValid), .txReady(txReady),
      .slow(slow));
   always @(negedge clk) begin
      clears += (clearEncoder === 1'b1);
      restarts += (moduleRestart === 1'b1);
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("Checks %0d failures %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Empty expectation means no reply at all
   task automatic xfer(input byte_t m[6], input logic bad, input byte_t exp[$]);
      word_t c;
      c = `CRC_INIT;
      u_master.send(m, bad);
      for (int i = 0; i < 60 && u_master.reply.size() < exp.size() + 2; i++) begin
         @(posedge clk);
      end
      repeat (4) @(posedge clk);
      check("reply length", u_master.reply.size(), exp.size() + (exp.size() ? 2 : 0));
      foreach (exp[i]) begin
         check("reply byte", u_master.reply[i], exp[i]);
         c = u_master.crc_step(c, exp[i]);
      end
      if (exp.size() > 0) begin
         check("reply crc", {u_master.reply[exp.size() + 1], u_master.reply[exp.size()]}, c);
      end
   endtask
   task automatic settings(input byte_t a, input baud_t b, input parity_t p, input int n);
      #1;
      check("address", stationAddr, a);
      check("baud", baudCode, b);
      check("parity", parityCode, p);
      check("restarts", restarts, n);
   endtask
   initial begin
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      settings(8'h02, 4'h6, 2'h0, 0);
      $display("Test reset done");
      xfer('{8'h02, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02}, 1'b0,
         '{8'h02, 8'h03, 8'h04, 8'hCA, 8'h90, 8'hFF, 8'hFF});
      slow <= 1'b1;
      xfer('{8'h02, 8'h03, 8'h00, 8'h20, 8'h00, 8'h02}, 1'b0,
         '{8'h02, 8'h03, 8'h04, 8'hAB, 8'hCD, 8'h12, 8'h34});
      xfer('{8'h02, 8'h03, 8'h00, 8'hD2, 8'h00, 8'h01}, 1'b0,
         '{8'h02, 8'h03, 8'h02, 8'hA5, 8'hC3});
      $display("Test reads done");
      xfer('{8'h02, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02}, 1'b1, '{});
      foreach (badFrames[i]) begin
         xfer(badFrames[i], 1'b0, '{});
      end
      $display("Test refusals done");
      xfer('{8'h02, 8'h06, 8'h00, 8'h43, 8'h00, 8'h0A}, 1'b0,
         '{8'h02, 8'h06, 8'h00, 8'h43, 8'h00, 8'h0A});
      check("clears", clears, 1);
      $display("Test clear done");
      xfer('{8'h02, 8'h06, 8'h00, 8'hC8, 8'h00, 8'h05}, 1'b0,
         '{8'h02, 8'h06, 8'h00, 8'hC8, 8'h00, 8'h05});
      xfer('{8'h02, 8'h06, 8'h00, 8'hC9, 8'h00, 8'h0A}, 1'b0,
         '{8'h02, 8'h06, 8'h00, 8'hC9, 8'h00, 8'h0A});
      xfer('{8'h02, 8'h06, 8'h00, 8'hCA, 8'h00, 8'h02}, 1'b0,
         '{8'h02, 8'h06, 8'h00, 8'hCA, 8'h00, 8'h02});
      xfer('{8'h02, 8'h03, 8'h00, 8'hC8, 8'h00, 8'h03}, 1'b0,
         '{8'h02, 8'h03, 8'h06, 8'h00, 8'h05, 8'h00, 8'h0A, 8'h00, 8'h02});
      settings(8'h02, 4'h6, 2'h0, 0);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      repeat (3) @(posedge clk);
      settings(8'h05, 4'hA, 2'h2, 1);
      $display("Test settings done");
      xfer('{8'h05, 8'h06, 8'h00, 8'h58, 8'hFF, 8'h00}, 1'b0,
         '{8'h05, 8'h06, 8'h00, 8'h58, 8'hFF, 8'h00});
      repeat (4) @(posedge clk);
      settings(8'h02, 4'h6, 2'h0, 2);
      $display("Test restore done");
      end_of_test();
   end
endmodule
`default_nettype wire

// ### hdl/crc16_engine.sv
// Purpose: Byte-wise CRC-16 of a Modbus RTU frame
// Assumes: clear and enable not asserted together
// Notes: Residue is zero after a frame whose trailing CRC is good
`timescale 1ns/1ps
`include "modbus_counter_regs.svh"
`default_nettype none
module crc16_engine
   import modbus_counter_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Byte feed
   input wire logic clear,
   input wire logic enable,
   input wire modbus_counter_pkg::byte_t dataIn,
   // Result
   output modbus_counter_pkg::word_t crc
);
   function automatic word_t crcStep(input word_t c, input byte_t d);
      word_t r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   word_t next_crc;

   always_comb begin
      next_crc = crc;
      if (clear) begin
         next_crc = `CRC_INIT;
      end else if (enable) begin
         next_crc = crcStep(crc, dataIn);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crc <= `CRC_INIT;
      end else begin
         crc <= next_crc;
      end
   end
endmodule
`default_nettype wire

// ### hdl/modbus_rtu_counter_slave.sv
// Purpose: Modbus RTU slave front end of an encoder counting module
// Assumes: A UART outside delivers bytes and flags the silent gap ending a frame
// Notes: Half duplex; bytes arriving while a reply is going out are dropped
`timescale 1ns/1ps
`include "modbus_counter_regs.svh"
`default_nettype none
// Overview of operation
// - Baud codes 4 to 10, applied at restart
// - Station address 0 to 255, applied at restart
// - Parity 0 none, 1 odd, 2 even
// - Read reply: address, 03, byte count, data, CRC
// - Encoder count at 0x10, low half first
// - Channel count at 0x20, low half first
// - Writing 0x000A to 0x43 clears encoder
// - Successful single write echoes the request
// - Writing 0xFF00 restores defaults, then restarts
module modbus_rtu_counter_slave
   import modbus_counter_pkg::*;
#(
   parameter int MAX_REGS = 16,
   parameter logic [7:0] DEF_ADDR = 8'h02,
   parameter logic [3:0] DEF_BAUD = 4'h6,
   parameter logic [1:0] DEF_PARITY = 2'h0,
   // Value is arbitrary
   parameter logic [15:0] MODULE_ID = 16'hA5C3
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Received bytes
   input wire modbus_counter_pkg::byte_t rxData,
   input wire logic rxValid,
   input wire logic rxFrameEnd,
   // Transmitted bytes
   output modbus_counter_pkg::byte_t txData,
   output logic txValid,
   input wire logic txReady,
   // Counts
   input wire logic [31:0] encoderCount,
   input wire logic [31:0] channelCount,
   output logic clearEncoder,
   // Restart and active settings
   input wire logic restart,
   output logic moduleRestart,
   output modbus_counter_pkg::byte_t stationAddr,
   output modbus_counter_pkg::baud_t baudCode,
   output modbus_counter_pkg::parity_t parityCode
);
   import modbus_counter_pkg::*;

   if (MAX_REGS < 1 || MAX_REGS > 125) begin : g_check
      $error("MAX_REGS must be 1 to 125");
   end

   tx_state_t state, next_state;
   logic [63:0] rxBuf, next_rxBuf;
   logic [3:0] rxCount, next_rxCount;
   logic [7:0] txIdx, next_txIdx, txLen, next_txLen;
   byte_t next_txData;
   logic reqRead, next_reqRead;
   word_t reqReg, next_reqReg, reqVal, next_reqVal;
   logic [31:0] encSnap, next_encSnap, chaSnap, next_chaSnap;
   byte_t pendAddr, next_pendAddr, next_stationAddr;
   baud_t pendBaud, next_pendBaud, next_baudCode;
   parity_t pendParity, next_pendParity, next_parityCode;
   logic restartPending, next_restartPending;
   logic next_clearEncoder, next_moduleRestart;
   word_t rxCrc, txCrc;
   logic rxCrcClear, txCrcClear, txFire;

   // Request fields, first byte oldest
   byte_t fAddr, fCode;
   word_t fReg, fVal;
   assign fAddr = rxBuf[63:56];
   assign fCode = rxBuf[55:48];
   assign fReg = rxBuf[47:32];
   assign fVal = rxBuf[31:16];

   assign txValid = (state == TX_SEND) || (state == TX_CRCLO) || (state == TX_CRCHI);
   assign txFire = txValid && txReady;

   function automatic logic writeLegal(input word_t r, input word_t v);
      unique case (r)
         `REG_CLEAR: return v == `VAL_CLEAR_ENC;
         `REG_RESTORE: return v == `VAL_RESTORE;
         `REG_ADDR: return v <= `ADDR_MAX;
         `REG_BAUD: return v >= `BAUD_MIN && v <= `BAUD_MAX;
         `REG_PARITY: return v <= `PARITY_MAX;
         default: return 1'b0;
      endcase
   endfunction

   function automatic word_t regValue(input word_t r);
      unique case (r)
         `REG_ENC_LO: return encSnap[15:0];
         `REG_ENC_HI: return encSnap[31:16];
         `REG_CHA_LO: return chaSnap[15:0];
         `REG_CHA_HI: return chaSnap[31:16];
         `REG_ADDR: return {8'h00, pendAddr};
         `REG_BAUD: return {12'h000, pendBaud};
         `REG_PARITY: return {14'h0000, pendParity};
         `REG_MODULE_ID: return MODULE_ID;
         default: return 16'h0000;
      endcase
   endfunction

   // Reply byte at position idx, position 0 being the address
   function automatic byte_t replyByte(input logic [7:0] idx);
      logic [7:0] k;
      word_t w;
      k = idx - `HDR_LEN;
      w = regValue(reqReg + {9'h000, k[7:1]});
      if (reqRead) begin
         unique case (idx)
            8'h00: return stationAddr;
            8'h01: return `FC_READ_HOLD;
            8'h02: return txLen - `HDR_LEN;
            default: return k[0] ? w[7:0] : w[15:8];
         endcase
      end else begin
         unique case (idx)
            8'h00: return stationAddr;
            8'h01: return `FC_WRITE_ONE;
            8'h02: return reqReg[15:8];
            8'h03: return reqReg[7:0];
            8'h04: return reqVal[15:8];
            default: return reqVal[7:0];
         endcase
      end
   endfunction

   always_comb begin
      logic frameOk, readOk, writeOk, doRestart;
      frameOk = 1'b0;
      readOk = 1'b0;
      writeOk = 1'b0;
      doRestart = 1'b0;
      next_state = state;
      next_rxBuf = rxBuf;
      next_rxCount = rxCount;
      next_txIdx = txIdx;
      next_txLen = txLen;
      next_txData = txData;
      next_reqRead = reqRead;
      next_reqReg = reqReg;
      next_reqVal = reqVal;
      next_encSnap = encSnap;
      next_chaSnap = chaSnap;
      next_pendAddr = pendAddr;
      next_pendBaud = pendBaud;
      next_pendParity = pendParity;
      next_stationAddr = stationAddr;
      next_baudCode = baudCode;
      next_parityCode = parityCode;
      next_restartPending = restartPending;
      next_clearEncoder = 1'b0;
      next_moduleRestart = 1'b0;
      rxCrcClear = 1'b0;
      txCrcClear = 1'b0;

      // Receive; count saturates one past a full request so longer frames are dropped
      if (state == TX_IDLE && rxValid) begin
         next_rxBuf = {rxBuf[55:0], rxData};
         if (rxCount <= `REQ_LEN) begin
            next_rxCount = rxCount + 4'h1;
         end
      end
      if (rxFrameEnd) begin
         next_rxCount = 4'h0;
         rxCrcClear = 1'b1;
         frameOk = state == TX_IDLE && rxCount == `REQ_LEN && rxCrc == 16'h0000 &&
            fAddr == stationAddr;
         readOk = frameOk && fCode == `FC_READ_HOLD && fVal != 16'h0000 &&
            fVal <= 16'(MAX_REGS);
         writeOk = frameOk && fCode == `FC_WRITE_ONE && writeLegal(fReg, fVal);
      end

      if (readOk || writeOk) begin
         // Snapshot so both halves of a count come from the same instant
         next_encSnap = encoderCount;
         next_chaSnap = channelCount;
         next_reqRead = readOk;
         next_reqReg = fReg;
         next_reqVal = fVal;
         next_txLen = readOk ? `HDR_LEN + {fVal[6:0], 1'b0} : `WR_LEN;
         next_txData = stationAddr;
         next_txIdx = 8'h01;
         txCrcClear = 1'b1;
         next_state = TX_SEND;
      end

      if (writeOk) begin
         unique case (fReg)
            `REG_CLEAR: next_clearEncoder = 1'b1;
            `REG_ADDR: next_pendAddr = fVal[7:0];
            `REG_BAUD: next_pendBaud = fVal[3:0];
            `REG_PARITY: next_pendParity = fVal[1:0];
            default: begin
               // Restore; restart waits until the echo is out
               next_pendAddr = DEF_ADDR;
               next_pendBaud = DEF_BAUD;
               next_pendParity = DEF_PARITY;
               next_restartPending = 1'b1;
            end
         endcase
      end

      unique case (state)
         TX_IDLE: begin
            doRestart = restart || restartPending;
         end
         TX_SEND: begin
            if (txFire) begin
               if (txIdx == txLen) begin
                  next_state = TX_CRCWAIT;
               end else begin
                  next_txData = replyByte(txIdx);
                  next_txIdx = txIdx + 8'h01;
               end
            end
         end
         TX_CRCWAIT: begin
            next_txData = txCrc[7:0];
            next_state = TX_CRCLO;
         end
         TX_CRCLO: begin
            if (txFire) begin
               next_txData = txCrc[15:8];
               next_state = TX_CRCHI;
            end
         end
         TX_CRCHI: begin
            if (txFire) begin
               next_state = TX_IDLE;
            end
         end
      endcase

      // Stored settings become active only here
      if (doRestart) begin
         next_stationAddr = pendAddr;
         next_baudCode = pendBaud;
         next_parityCode = pendParity;
         // A restore taken in this same cycle keeps its pending restart
         next_restartPending = writeOk && fReg == `REG_RESTORE;
         next_moduleRestart = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= TX_IDLE;
         rxBuf <= 64'h0000_0000_0000_0000;
         rxCount <= 4'h0;
         txIdx <= 8'h00;
         txLen <= 8'h00;
         txData <= 8'h00;
         reqRead <= 1'b0;
         reqReg <= 16'h0000;
         reqVal <= 16'h0000;
         encSnap <= 32'h0000_0000;
         chaSnap <= 32'h0000_0000;
         pendAddr <= DEF_ADDR;
         pendBaud <= DEF_BAUD;
         pendParity <= DEF_PARITY;
         stationAddr <= DEF_ADDR;
         baudCode <= DEF_BAUD;
         parityCode <= DEF_PARITY;
         restartPending <= 1'b0;
         clearEncoder <= 1'b0;
         moduleRestart <= 1'b0;
      end else begin
         state <= next_state;
         rxBuf <= next_rxBuf;
         rxCount <= next_rxCount;
         txIdx <= next_txIdx;
         txLen <= next_txLen;
         txData <= next_txData;
         reqRead <= next_reqRead;
         reqReg <= next_reqReg;
         reqVal <= next_reqVal;
         encSnap <= next_encSnap;
         chaSnap <= next_chaSnap;
         pendAddr <= next_pendAddr;
         pendBaud <= next_pendBaud;
         pendParity <= next_pendParity;
         stationAddr <= next_stationAddr;
         baudCode <= next_baudCode;
         parityCode <= next_parityCode;
         restartPending <= next_restartPending;
         clearEncoder <= next_clearEncoder;
         moduleRestart <= next_moduleRestart;
      end
   end

   crc16_engine u_rxCrc (
      .clk(clk),
      .rstn(rstn),
      .clear(rxCrcClear),
      .enable(state == TX_IDLE && rxValid),
      .dataIn(rxData),
      .crc(rxCrc)
   );

   crc16_engine u_txCrc (
      .clk(clk),
      .rstn(rstn),
      .clear(txCrcClear),
      .enable(state == TX_SEND && txFire),
      .dataIn(txData),
      .crc(txCrc)
   );
endmodule
`default_nettype wire

// ### inc/modbus_counter_pkg.sv
// Purpose: Types shared by the Modbus counter slave
// Assumes: Nothing
// Notes: Constants live in the regs header
package modbus_counter_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
   typedef logic [3:0] baud_t;
   typedef logic [1:0] parity_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_SEND = 3'h1,
      TX_CRCWAIT = 3'h3,
      TX_CRCLO = 3'h2,
      TX_CRCHI = 3'h6
   } tx_state_t;
endpackage

// ### inc/modbus_counter_regs.svh
// Purpose: Register numbers, codes and field values of the Modbus counter slave
// Assumes: Register numbers are the zero-based protocol addresses
// Notes: Definitions only
`ifndef MODBUS_COUNTER_REGS_SVH
`define MODBUS_COUNTER_REGS_SVH

// Function codes
`define FC_READ_HOLD 8'h03
`define FC_WRITE_ONE 8'h06

// Register numbers
`define REG_ENC_LO 16'h0010
`define REG_ENC_HI 16'h0011
`define REG_CHA_LO 16'h0020
`define REG_CHA_HI 16'h0021
`define REG_CLEAR 16'h0043
`define REG_RESTORE 16'h0058
`define REG_ADDR 16'h00C8
`define REG_BAUD 16'h00C9
`define REG_PARITY 16'h00CA
`define REG_MODULE_ID 16'h00D2

// Command and range values
`define VAL_CLEAR_ENC 16'h000A
`define VAL_RESTORE 16'hFF00
`define ADDR_MAX 16'h00FF
`define BAUD_MIN 16'h0004
`define BAUD_MAX 16'h000A
`define PARITY_MAX 16'h0002

// Frame layout
`define REQ_LEN 4'h8
`define HDR_LEN 8'h03
`define WR_LEN 8'h06

// CRC
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001

`endif
